/* logic/mnn_pkg.sv */
package mnn_pkg;
  localparam int ID_W = 6;
  localparam int ROW_LO = 26;
  localparam int COL_LO = 20;
  localparam logic [31:0] LOCAL_TOP = 32'h0000_7FFF;
  localparam int CHIP_SHIFT = 2;
  localparam int NPORT = 5;
  localparam int P_WR = 0;
  localparam int P_RD = 1;
  localparam int P_XW = 2;
  localparam logic [2:0] D_N = 3'h0;
  localparam logic [2:0] D_E = 3'h1;
  localparam logic [2:0] D_W = 3'h2;
  localparam logic [2:0] D_S = 3'h3;
  localparam logic [2:0] D_LOC = 3'h4;
  localparam int RD_GAP_CYC = 8;
  localparam int HOP_HALF_CYC = 3;
  localparam int HOP_CYC = (HOP_HALF_CYC + 1) / 2;
  localparam int BUF_DEPTH = 2;

  typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD, SZ_DOUBLE} mnn_size_t;

  typedef struct packed {
    logic isReply;
    logic write;
    mnn_size_t size;
    logic [31:0] dest;
    logic [31:0] src;
    logic [63:0] data;
  } mnn_txn_t;

  typedef struct packed {
    logic write;
    mnn_size_t size;
    logic [31:0] addr;
    logic [63:0] data;
  } mnn_core_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    mnn_size_t size;
    logic [31:0] addr;
    logic [63:0] data;
  } mnn_mem_req_t;

  function automatic logic [5:0] mnn_row(input logic [31:0] a);
    return a[ROW_LO+:ID_W];
  endfunction

  function automatic logic [5:0] mnn_col(input logic [31:0] a);
    return a[COL_LO+:ID_W];
  endfunction

  function automatic logic mnn_is_local(input logic [31:0] a,
      input logic [5:0] row, input logic [5:0] col);
    return (a <= LOCAL_TOP) || (mnn_row(a) == row && mnn_col(a) == col);
  endfunction

  function automatic logic mnn_off_chip(input logic [31:0] a,
      input logic [5:0] row, input logic [5:0] col);
    return ((mnn_row(a) >> CHIP_SHIFT) != (row >> CHIP_SHIFT)) ||
      ((mnn_col(a) >> CHIP_SHIFT) != (col >> CHIP_SHIFT));
  endfunction

  function automatic logic mnn_misaligned(input logic [2:0] a,
      input mnn_size_t s);
    case (s)
      SZ_HALF: return a[0] != 1'b0;
      SZ_WORD: return a[1:0] != 2'h0;
      SZ_DOUBLE: return a != 3'h0;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [2:0] mnn_route(input int p, input int i,
      input logic [31:0] dest, input logic [5:0] row, input logic [5:0] col);
    logic [2:0] d;
    logic ewIn;
    logic ewOut;
    if (mnn_col(dest) < col) d = D_E;
    else if (mnn_col(dest) > col) d = D_W;
    else if (mnn_row(dest) < row) d = D_N;
    else if (mnn_row(dest) > row) d = D_S;
    else d = D_LOC;
    ewIn = (i == int'(D_E)) || (i == int'(D_W));
    ewOut = (d == D_E) || (d == D_W);
    if (p == P_XW && i != int'(D_LOC) && d != D_LOC && ewIn != ewOut) begin
      d = D_LOC;
    end
    return d;
  endfunction
endpackage

/* logic/mnn_rr_arb.sv */
`timescale 1ns/1ps
`default_nettype none
module mnn_rr_arb (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [4:0] req,
  input wire logic advance,
  output logic [4:0] grant
);
  logic [2:0] last;
  logic [2:0] sel;

  always_comb begin
    int idx;
    idx = 0;
    grant = 5'h00;
    sel = last;
    for (int k = 1; k <= mnn_pkg::NPORT; k++) begin
      idx = (int'(last) + k) % mnn_pkg::NPORT;
      if (grant == 5'h00 && req[idx]) begin
        grant[idx] = 1'b1;
        sel = 3'(idx);
      end
    end
  end

  // Winner becomes lowest priority
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last <= 3'h4;
    end else if (advance) begin
      last <= sel;
    end
  end
endmodule
`default_nettype wire

/* logic/mnn_router.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Addresses are unsigned byte addresses over a flat 32-bit space.
// - A word is aligned when its address divides by four.
// - Node identity is six row and six column bits at the top.
// - Addresses up to the alias bound reach the node's own memory.
// - Any node reaches any other by its row and column, no setup.
// - Reads carry a return address; the target sends data back there.
// - Local memory accesses complete in dispatch order.
// - Remote loads return before use; stores always reach destination.
// - Read-read, write-write, read-write, read-then-other stay ordered.
// - Data is little-endian, least significant byte at lowest address.
// - Alignment checks low three address bits per access size.
// - A misaligned load or store raises an exception.
// - A misaligned write is still performed.
// - A misaligned read returns data before the exception.
// - Router links only to north, east, west, south and own node.
// - Write plane hop latency is one and a half cycles; this router rounds it up to two cycles.
// - Three planes: on-chip writes, read requests, off-chip writes.
// - On-chip write plane moves eight bytes per cycle each way.
// - Read plane sends at most one read per eight cycles per way.
// - Off-chip plane is two networks, south-north and east-west.
// - Fixed dimension-ordered routing keeps the network deadlock free.
// - Column compared first, then row; both match delivers locally.
// - Each output arbitrates its inputs round robin.
module mnn_router #(
  parameter logic [3:0] EDGE_TIED = 4'h0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [5:0] rowIdPin,
  input wire logic [5:0] colIdPin,
  input wire mnn_pkg::mnn_txn_t [2:0][3:0] linkInTxn,
  input wire logic [2:0][3:0] linkInValid,
  output logic [2:0][3:0] linkInWait,
  output mnn_pkg::mnn_txn_t [2:0][3:0] linkOutTxn,
  output logic [2:0][3:0] linkOutValid,
  input wire logic [2:0][3:0] linkOutWait,
  input wire logic coreValid,
  input wire mnn_pkg::mnn_core_req_t coreReq,
  output logic coreWait,
  output logic [63:0] coreRdData,
  output logic coreRdValid,
  output logic alignExc,
  output mnn_pkg::mnn_mem_req_t memReq,
  input wire logic [63:0] memRdData
);
  typedef enum logic [1:0] {CS_IDLE, CS_MEMRD, CS_INJ, CS_RDWAIT}
    mnn_cstate_t;

  logic [5:0] rowMeta, colMeta, rowId, colId;
  mnn_pkg::mnn_txn_t bufTxn [3][5][2];
  logic [1:0] cnt [3][5];
  logic [2:0][4:0] bufWait, inValid, push, pop;
  logic [2:0][4:0] outValid, outFree, ld;
  mnn_pkg::mnn_txn_t inTxn [3][5];
  mnn_pkg::mnn_txn_t outTxn [3][5];
  logic [4:0] gnt [3][5];
  logic [2:0] take;
  logic [3:0] gapCnt [4];
  mnn_cstate_t cs, next_cs;
  mnn_pkg::mnn_core_req_t coreHold;
  mnn_pkg::mnn_txn_t coreTxn, replyTxn, svcTxn, injTxn;
  logic coreAcc, reqLocal, coreMis, useCore, alignPend;
  logic wr0Go, wr2Go, svcGo, replyHit, coreInjDone, replyDone;
  logic replyValid;
  logic [2:0] injValid;
  logic [1:0] rdCore, rdSvc, corePlane, replyPlane;

  // ******************************************************
  // Node identity straps
  // ******************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rowMeta <= 6'h00;
      colMeta <= 6'h00;
      rowId <= 6'h00;
      colId <= 6'h00;
    end else begin
      rowMeta <= rowIdPin;
      colMeta <= colIdPin;
      rowId <= rowMeta;
      colId <= colMeta;
    end
  end

  // ******************************************************
  // Link ports and tied edges
  // ******************************************************
  for (genvar p = 0; p < 3; p++) begin : g_link
    for (genvar d = 0; d < 4; d++) begin : g_dir
      assign inValid[p][d] = linkInValid[p][d] & ~EDGE_TIED[d];
      assign inTxn[p][d] = linkInTxn[p][d];
      assign linkInWait[p][d] = bufWait[p][d];
      assign linkOutValid[p][d] = outValid[p][d];
      assign linkOutTxn[p][d] = outTxn[p][d];
    end
  end

  // Own node input of each plane
  for (genvar p = 0; p < 3; p++) begin : g_inj
    assign inValid[p][4] = injValid[p];
    assign inTxn[p][4] = injTxn;
  end

  // ******************************************************
  // Input buffers, two deep for full link rate
  // ******************************************************
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      for (int i = 0; i < 5; i++) begin
        push[p][i] = inValid[p][i] && !bufWait[p][i];
        pop[p][i] = 1'b0;
        for (int o = 0; o < 5; o++) begin
          pop[p][i] = pop[p][i] | (gnt[p][o][i] & outFree[p][o]);
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int p = 0; p < 3; p++) begin
        for (int i = 0; i < 5; i++) begin
          cnt[p][i] <= 2'h0;
          bufWait[p][i] <= 1'b0;
        end
      end
    end else begin
      for (int p = 0; p < 3; p++) begin
        for (int i = 0; i < 5; i++) begin
          if (push[p][i] && !pop[p][i]) begin
            cnt[p][i] <= cnt[p][i] + 2'h1;
            bufWait[p][i] <= cnt[p][i] == 2'h1;
          end else if (pop[p][i] && !push[p][i]) begin
            cnt[p][i] <= cnt[p][i] - 2'h1;
            bufWait[p][i] <= 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int p = 0; p < 3; p++) begin
      for (int i = 0; i < 5; i++) begin
        if (pop[p][i]) begin
          bufTxn[p][i][0] <= bufTxn[p][i][1];
        end
        if (push[p][i]) begin
          if (cnt[p][i] == 2'h0 || (cnt[p][i] == 2'h1 && pop[p][i])) begin
            bufTxn[p][i][0] <= inTxn[p][i];
          end else begin
            bufTxn[p][i][1] <= inTxn[p][i];
          end
        end
      end
    end
  end

  // ******************************************************
  // Route and round-robin arbitration per output
  // ******************************************************
  for (genvar p = 0; p < 3; p++) begin : g_pl
    for (genvar o = 0; o < 5; o++) begin : g_out
      logic [4:0] req;
      always_comb begin
        for (int i = 0; i < 5; i++) begin
          req[i] = (cnt[p][i] != 2'h0) && (mnn_pkg::mnn_route(p, i,
            bufTxn[p][i][0].dest, rowId, colId) == 3'(o));
        end
      end
      assign ld[p][o] = outFree[p][o] && (gnt[p][o] != 5'h00);
      mnn_rr_arb u_arb (
        .clk(clk),
        .resetn(resetn),
        .req(req),
        .advance(ld[p][o]),
        .grant(gnt[p][o])
      );
    end
  end

  always_comb begin
    for (int p = 0; p < 3; p++) begin
      for (int o = 0; o < 4; o++) begin
        outFree[p][o] = !outValid[p][o] ||
          (!linkOutWait[p][o] && !EDGE_TIED[o]);
        if (p == mnn_pkg::P_RD && gapCnt[o] != 4'h0) begin
          outFree[p][o] = 1'b0;
        end
      end
      outFree[p][4] = !outValid[p][4] || take[p];
    end
  end

  // ******************************************************
  // Output registers, one hop of pipeline
  // ******************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      outValid <= '0;
    end else begin
      for (int p = 0; p < 3; p++) begin
        for (int o = 0; o < 5; o++) begin
          if (ld[p][o]) begin
            outValid[p][o] <= 1'b1;
          end else if (o < 4 ? (!linkOutWait[p][o] && !EDGE_TIED[o])
              : take[p]) begin
            outValid[p][o] <= 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int p = 0; p < 3; p++) begin
      for (int o = 0; o < 5; o++) begin
        for (int i = 0; i < 5; i++) begin
          if (ld[p][o] && gnt[p][o][i]) begin
            outTxn[p][o] <= bufTxn[p][i][0];
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int o = 0; o < 4; o++) begin
        gapCnt[o] <= 4'h0;
      end
    end else begin
      for (int o = 0; o < 4; o++) begin
        if (ld[mnn_pkg::P_RD][o]) begin
          gapCnt[o] <= 4'(mnn_pkg::RD_GAP_CYC - 1);
        end else if (gapCnt[o] != 4'h0) begin
          gapCnt[o] <= gapCnt[o] - 4'h1;
        end
      end
    end
  end

  // ******************************************************
  // Core requests, decode and local sinks
  // ******************************************************
  always_comb begin
    coreAcc = coreValid && !coreWait;
    reqLocal = mnn_pkg::mnn_is_local(coreReq.addr, rowId, colId);
    coreMis = mnn_pkg::mnn_misaligned(coreReq.addr[2:0],
      coreReq.size);
    useCore = coreAcc && reqLocal;
    take[mnn_pkg::P_WR] = outValid[0][4] &&
      (outTxn[0][4].isReply || !useCore);
    wr0Go = take[mnn_pkg::P_WR] && !outTxn[0][4].isReply;
    take[mnn_pkg::P_XW] = outValid[2][4] &&
      (outTxn[2][4].isReply || (!useCore && !wr0Go));
    wr2Go = take[mnn_pkg::P_XW] && !outTxn[2][4].isReply;
    svcGo = outValid[1][4] && !useCore && !wr0Go && !wr2Go &&
      !replyValid && rdSvc == 2'h0;
    take[mnn_pkg::P_RD] = svcGo;
    replyHit = (take[0] && outTxn[0][4].isReply) ||
      (take[2] && outTxn[2][4].isReply);
    coreTxn = '{isReply: 1'b0, write: coreHold.write,
      size: coreHold.size, dest: coreHold.addr,
      src: {rowId, colId, coreHold.addr[19:0]},
      data: coreHold.data};
    if (!coreHold.write) begin
      corePlane = 2'(mnn_pkg::P_RD);
    end else if (mnn_pkg::mnn_off_chip(coreHold.addr, rowId, colId)) begin
      corePlane = 2'(mnn_pkg::P_XW);
    end else begin
      corePlane = 2'(mnn_pkg::P_WR);
    end
    replyPlane = mnn_pkg::mnn_off_chip(replyTxn.dest, rowId, colId) ?
      2'(mnn_pkg::P_XW) : 2'(mnn_pkg::P_WR);
    for (int p = 0; p < 3; p++) begin
      injValid[p] = replyValid ? (replyPlane == 2'(p)) :
        (cs == CS_INJ && corePlane == 2'(p));
    end
    injTxn = replyValid ? replyTxn : coreTxn;
    coreInjDone = cs == CS_INJ && !replyValid && push[corePlane][4];
    replyDone = replyValid && push[replyPlane][4];
  end

  always_comb begin
    next_cs = cs;
    case (cs)
      CS_IDLE: begin
        if (coreAcc && reqLocal) begin
          next_cs = coreReq.write ? CS_IDLE : CS_MEMRD;
        end else if (coreAcc) begin
          next_cs = CS_INJ;
        end
      end
      CS_MEMRD: begin
        if (rdCore[1]) next_cs = CS_IDLE;
      end
      CS_INJ: begin
        if (coreInjDone) next_cs = coreHold.write ? CS_IDLE : CS_RDWAIT;
      end
      default: begin
        if (replyHit) next_cs = CS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cs <= CS_IDLE;
      coreWait <= 1'b0;
      coreHold <= '0;
    end else begin
      cs <= next_cs;
      coreWait <= next_cs != CS_IDLE;
      if (coreAcc) coreHold <= coreReq;
    end
  end

  // ******************************************************
  // Memory port, read service and replies
  // ******************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      memReq <= '0;
    end else if (useCore) begin
      memReq <= '{1'b1, coreReq.write, coreReq.size, coreReq.addr,
        coreReq.data};
    end else if (wr0Go || wr2Go) begin
      memReq <= wr0Go ?
        '{1'b1, 1'b1, outTxn[0][4].size, outTxn[0][4].dest,
          outTxn[0][4].data} :
        '{1'b1, 1'b1, outTxn[2][4].size, outTxn[2][4].dest,
          outTxn[2][4].data};
    end else if (svcGo) begin
      memReq <= '{1'b1, 1'b0, outTxn[1][4].size, outTxn[1][4].dest,
        64'h0000_0000_0000_0000};
    end else begin
      memReq.valid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdCore <= 2'h0;
      rdSvc <= 2'h0;
      replyValid <= 1'b0;
      svcTxn <= '0;
      replyTxn <= '0;
    end else begin
      rdCore <= {rdCore[0], useCore && !coreReq.write};
      rdSvc <= {rdSvc[0], svcGo};
      if (svcGo) svcTxn <= outTxn[1][4];
      if (rdSvc[1]) begin
        replyValid <= 1'b1;
        replyTxn <= '{isReply: 1'b1, write: 1'b1, size: svcTxn.size,
          dest: svcTxn.src, src: svcTxn.dest, data: memRdData};
      end else if (replyDone) begin
        replyValid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      coreRdValid <= 1'b0;
      coreRdData <= 64'h0000_0000_0000_0000;
      alignPend <= 1'b0;
      alignExc <= 1'b0;
    end else begin
      coreRdValid <= rdCore[1] || replyHit;
      if (rdCore[1]) begin
        coreRdData <= memRdData;
      end else if (replyHit) begin
        coreRdData <= take[0] && outTxn[0][4].isReply ?
          outTxn[0][4].data : outTxn[2][4].data;
      end
      if (coreAcc && !coreReq.write && coreMis) begin
        alignPend <= 1'b1;
      end else if (coreRdValid) begin
        alignPend <= 1'b0;
      end
      alignExc <= (coreAcc && coreReq.write && coreMis) ||
        (alignPend && coreRdValid);
    end
  end

  // ******************************************************
  // Assertions
  // ******************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  misalign_wr_exc_a: assert property (
    coreAcc && coreReq.write && coreMis |=> alignExc)
    else $error("misaligned write raised no exception");
  misalign_wr_mem_a: assert property (
    useCore && coreReq.write && coreMis |=> memReq.valid && memReq.write)
    else $error("misaligned write not performed");
  rd_before_exc_a: assert property (
    alignExc && !$past(coreAcc && coreReq.write) |-> $past(coreRdValid))
    else $error("read exception before read data");
  alias_local_a: assert property (
    coreAcc && coreReq.addr <= mnn_pkg::LOCAL_TOP |=> memReq.valid)
    else $error("alias address not served locally");
  local_order_a: assert property (
    useCore && !coreReq.write |=> coreWait [*2] ##1 coreRdValid)
    else $error("local read out of order");
  remote_rd_hold_a: assert property (
    coreAcc && !coreReq.write && !reqLocal |=> coreWait [*2])
    else $error("core not held during remote read");
  hop_lat_a: assert property (
    push[0][2] && cnt[0][0] == 2'h0 && cnt[0][1] == 2'h0 &&
    cnt[0][2] == 2'h0 && cnt[0][3] == 2'h0 && cnt[0][4] == 2'h0 &&
    !outValid[0][1] && mnn_pkg::mnn_route(0, 2, inTxn[0][2].dest,
    rowId, colId) == mnn_pkg::D_E |-> ##2 outValid[0][1])
    else $error("write hop latency wrong");
  col_first_a: assert property (
    ld[0][1] |=> mnn_pkg::mnn_col(outTxn[0][1].dest) < colId)
    else $error("east output with wrong column");

  for (genvar d = 0; d < 4; d++) begin : g_chk
    rd_gap_a: assert property (
      ld[mnn_pkg::P_RD][d] |=> !ld[mnn_pkg::P_RD][d] [*7])
      else $error("read plane exceeded rate");
    link_hold_a: assert property (
      linkOutValid[0][d] && linkOutWait[0][d] |=>
      linkOutValid[0][d] && $stable(linkOutTxn[0][d]))
      else $error("link output dropped while waiting");
  end

  remote_reply_c: cover property (cs == CS_RDWAIT ##[1:40] replyHit);
  misread_exc_c: cover property (alignPend && coreRdValid ##1 alignExc);
  reply_sent_c: cover property (replyDone);
  rd_gap_c: cover property (ld[1][1] ##8 ld[1][1]);
endmodule
`default_nettype wire

/* testbench/mnn_mesh_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Local memory and neighbour sinks
// ****************************************
module mnn_mesh_partner (
  input wire logic clk,
  input wire logic resetn,
  input wire mnn_pkg::mnn_mem_req_t memReq,
  output logic [63:0] memRdData,
  input wire logic stall,
  output logic [2:0][3:0] linkOutWait
);
  // Keyed by node offset so the alias and the own global address meet
  logic [7:0] mem [logic [19:0]];
  logic [19:0] a;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      memRdData <= 64'h0;
      linkOutWait <= '0;
    end else begin
      // All neighbours refuse together while stalled
      linkOutWait <= {12{stall}};
      // Lanes not read toggle so stale data never looks valid
      memRdData <= ~memRdData;
      for (int i = 0; i < 8; i++) begin
        a = memReq.addr[19:0] + 20'(i);
        if (memReq.valid && i < (1 << memReq.size)) begin
          if (memReq.write) mem[a] = memReq.data[8*i+:8];
          else if (mem.exists(a)) memRdData[8*i+:8] <= mem[a];
        end
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/test_mesh_node_address_network.sv */
`timescale 1ns/1ps
`default_nettype none
module test_mesh_node_address_network;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [5:0] rowIdPin = 6'h05;
  logic [5:0] colIdPin = 6'h05;
  mnn_pkg::mnn_txn_t [2:0][3:0] linkInTxn = '0;
  mnn_pkg::mnn_txn_t [2:0][3:0] linkOutTxn;
  logic [2:0][3:0] linkInValid = '0;
  logic [2:0][3:0] linkInWait, linkOutValid, linkOutWait;
  logic coreValid = 1'b0;
  logic stall = 1'b0;
  logic coreWait, coreRdValid, alignExc;
  mnn_pkg::mnn_core_req_t coreReq = '0;
  mnn_pkg::mnn_mem_req_t memReq;
  logic [63:0] coreRdData, memRdData;
  int error_cnt = 0, n_checks = 0, cyc = 0, excCnt = 0, memWr = 0;
  int lastRd = -100;
  int seed = 32'hcb93_621c;
  logic [7:0] model [logic [19:0]];
  int tbl [9][6] = '{'{0,2,1,5,4,0}, '{0,1,2,5,6,1}, '{0,3,0,4,5,0},
    '{0,0,3,6,5,0}, '{0,2,1,4,4,0}, '{0,2,4,5,5,0}, '{1,0,3,7,5,0},
    '{1,0,3,7,5,0}, '{2,1,2,5,9,0}};
  int ctb [4][4] = '{'{5,7,0,2}, '{4,4,0,1}, '{9,5,2,3}, '{5,1,2,1}};
  always #25 clk = ~clk;
  mnn_router mnn_router_inst (.clk(clk), .resetn(resetn),
    .rowIdPin(rowIdPin), .colIdPin(colIdPin), .linkInTxn(linkInTxn),
    .linkInValid(linkInValid), .linkInWait(linkInWait),
    .linkOutTxn(linkOutTxn), .linkOutValid(linkOutValid),
    .linkOutWait(linkOutWait), .coreValid(coreValid), .coreReq(coreReq),
    .coreWait(coreWait), .coreRdData(coreRdData),
    .coreRdValid(coreRdValid), .alignExc(alignExc), .memReq(memReq),
    .memRdData(memRdData));
  mnn_mesh_partner mnn_mesh_partner_inst (.clk(clk), .resetn(resetn),
    .memReq(memReq), .memRdData(memRdData), .stall(stall),
    .linkOutWait(linkOutWait));
  // ****************************************
  // Checking and driving tasks
  // ****************************************
  task automatic finish_test;
    $display("Checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmpTxn(input mnn_pkg::mnn_txn_t got,
      input mnn_pkg::mnn_txn_t exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t txn got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] nodeAddr(input int r, input int c,
      input int off);
    return {6'(r), 6'(c), 20'(off)};
  endfunction
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (alignExc === 1'b1) excCnt <= excCnt + 1;
    if (memReq.valid === 1'b1 && memReq.write === 1'b1) memWr <= memWr + 1;
    if (linkOutValid[1][3] === 1'b1 && linkOutWait[1][3] === 1'b0) begin
      cmp(64'(cyc - lastRd >= mnn_pkg::RD_GAP_CYC), 64'h1);
      lastRd <= cyc;
    end
    if (cyc > 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  task core(input logic wr, input int sz, input logic [31:0] a,
      input logic [63:0] d);
    @(posedge clk);
    coreReq <= '{wr, mnn_pkg::mnn_size_t'(sz), a, d};
    coreValid <= 1'b1;
    do @(posedge clk); while (coreWait !== 1'b0);
    coreValid <= 1'b0;
  endtask
  task waitOut(input int p, input int o, output int n);
    n = 0;
    while (linkOutValid[p][o] !== 1'b1 && n < 30) begin
      @(posedge clk);
      n++;
    end
  endtask
  task waitRd(input logic [63:0] e, input logic [63:0] m);
    int n;
    n = 0;
    while (coreRdValid !== 1'b1 && n < 30) begin
      @(posedge clk);
      n++;
    end
    cmp(64'(coreRdValid), 64'h1);
    cmp(coreRdData & m, e);
  endtask
  task send(input int p, input int i, input mnn_pkg::mnn_txn_t t);
    linkInTxn[p][i] <= t;
    linkInValid[p][i] <= 1'b1;
    do @(posedge clk); while (linkInWait[p][i] !== 1'b0);
    linkInValid[p][i] <= 1'b0;
    linkInTxn[p][i] <= ~t;
  endtask
  task route(input int p, input int i, input int o, input logic [31:0] dst,
      input logic hold);
    mnn_pkg::mnn_txn_t t;
    int n;
    t = '{1'b0, p != 1, mnn_pkg::SZ_DOUBLE, dst, nodeAddr(5, 4, 'h300),
      {$random(seed), $random(seed)}};
    @(posedge clk);
    stall <= hold;
    send(p, i, t);
    if (o == 4) begin
      n = 0;
      while (memReq.valid !== 1'b1 && n < 30) begin
        @(posedge clk);
        n++;
      end
      cmp(64'(memReq.addr), 64'(dst));
      cmp(memReq.data, t.data);
    end else begin
      waitOut(p, o, n);
      if (p == 0 && !hold) cmp(64'(n), 64'(mnn_pkg::HOP_CYC));
      cmpTxn(linkOutTxn[p][o], t);
      if (hold) begin
        repeat (5) @(posedge clk);
        cmp(64'(linkOutValid[p][o]), 64'h1);
        cmpTxn(linkOutTxn[p][o], t);
        stall <= 1'b0;
      end
    end
    repeat (3) @(posedge clk);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] a;
    logic [63:0] d, e, m;
    mnn_pkg::mnn_txn_t t;
    int n, base, wbase, rs;
    logic mis;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    for (int sz = 0; sz < 4; sz++) begin
      for (int lo = 0; lo < 8; lo++) begin
        a = nodeAddr(5, 5, 'h1000 + lo);
        d = {$random(seed), $random(seed)};
        mis = (lo % (1 << sz)) != 0;
        base = excCnt;
        wbase = memWr;
        core(1'b1, sz, a, d);
        for (int i = 0; i < 16; i++) begin
          if (mis) model.delete(20'((a & ~32'h7) + i));
          else if (i < (1 << sz)) model[20'(a + i)] = d[8*i+:8];
        end
        repeat (6) @(posedge clk);
        cmp(64'(excCnt - base), 64'(mis));
        cmp(64'(memWr - wbase), 64'h1);
        rs = 3 - sz;
        mis = (lo % (1 << rs)) != 0;
        e = '0;
        m = '0;
        for (int i = 0; i < (1 << rs); i++) begin
          if (!mis && model.exists(20'(a + i))) begin
            e[8*i+:8] = model[20'(a + i)];
            m[8*i+:8] = 8'hff;
          end
        end
        base = excCnt;
        core(1'b0, rs, 32'(a[19:0]), 64'h0);
        waitRd(e, m);
        cmp(64'(excCnt - base), 64'h0);
        repeat (6) @(posedge clk);
        cmp(64'(excCnt - base), 64'(mis));
      end
    end
    for (int k = 0; k < 9; k++) begin
      a = nodeAddr(tbl[k][3], tbl[k][4], 'h200 + 8 * k);
      route(tbl[k][0], tbl[k][1], tbl[k][2], a, tbl[k][5] != 0);
    end
    for (int k = 0; k < 4; k++) begin
      d = {$random(seed), $random(seed)};
      a = nodeAddr(ctb[k][0], ctb[k][1], 'h40);
      core(1'b1, 3, a, d);
      waitOut(ctb[k][2], ctb[k][3], n);
      t = linkOutTxn[ctb[k][2]][ctb[k][3]];
      cmp(64'(t.dest), 64'(a));
      cmp(t.data, d);
      repeat (3) @(posedge clk);
    end
    a = nodeAddr(6, 5, 'h80);
    d = 64'(unsigned'($random(seed)));
    fork
      core(1'b0, 2, a, 64'h0);
      begin
        waitOut(1, 3, n);
        t = linkOutTxn[1][3];
        cmp(64'(t.src), 64'(nodeAddr(5, 5, 'h80)));
        cmp(64'(t.dest), 64'(a));
        t = '{1'b1, 1'b1, mnn_pkg::SZ_WORD, t.src, a, d};
        send(0, 3, t);
      end
    join
    waitRd(d, 64'h0000_0000_ffff_ffff);
    repeat (5) @(posedge clk);
    // ****************************************
    // Read request served by this node
    // ****************************************
    d = {$random(seed), $random(seed)};
    core(1'b1, 3, nodeAddr(5, 5, 'h2000), d);
    t = '{1'b0, 1'b0, mnn_pkg::SZ_DOUBLE, nodeAddr(5, 5, 'h2000),
      nodeAddr(5, 4, 'h40), 64'h0};
    send(1, 2, t);
    waitOut(0, 1, n);
    t = '{1'b1, 1'b1, mnn_pkg::SZ_DOUBLE, t.src, t.dest, d};
    cmpTxn(linkOutTxn[0][1], t);
    repeat (5) @(posedge clk);
    finish_test();
  end
endmodule
`default_nettype wire
